//--- verilog/fosq_regs.svh
// Register offsets, field positions, codes and constants of the flash command sequencer.
`ifndef FOSQ_REGS_SVH
`define FOSQ_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FOSQ_OFS_STATUS 3'h0
`define FOSQ_OFS_INDEX 3'h1
`define FOSQ_OFS_SLOT 3'h2
`define FOSQ_OFS_CONFIG 3'h3
`define FOSQ_OFS_PROTECT 3'h4

// ----------------------------------------------------------------
// Status, configuration and protection fields
// ----------------------------------------------------------------
`define FOSQ_BIT_COMMAND_COMPLETE_FLAG 7
`define FOSQ_BIT_ACCESS_ERROR_FLAG 5
`define FOSQ_BIT_PROTECTION_VIOLATION_FLAG 4
`define FOSQ_BIT_VERIFY 1
`define FOSQ_BIT_UNCORR 0
`define FOSQ_BIT_MODE_OK 0
`define FOSQ_BIT_PROT_EN 15

// ----------------------------------------------------------------
// Command codes and slot numbers
// ----------------------------------------------------------------
`define FOSQ_CMD_READ_ONCE 8'h04
`define FOSQ_CMD_PROG_PHRASE 8'h06
`define FOSQ_CMD_PROG_ONCE 8'h07
`define FOSQ_SLOT_CMD 3'h0
`define FOSQ_SLOT_PARAM 3'h1
`define FOSQ_SLOT_WORD0 3'h2
`define FOSQ_SLOT_LAST 3'h5
`define FOSQ_SLOT_COUNT 6
`define FOSQ_ONCE_MAX_INDEX 16'h0007

// ----------------------------------------------------------------
// Array constants and reset values
// ----------------------------------------------------------------
`define FOSQ_ERASED_WORD 16'hFFFF
`define FOSQ_INVALID_DATA 16'h0000
`define FOSQ_PFLASH_TOP 5'h1F
`define FOSQ_BLOCK0_TOP 5'h1F
`define FOSQ_CONFIG_RESET 16'h0001
`define FOSQ_PROTECT_RESET 16'h0000
`define FOSQ_LAST_WORD 2'h3

`endif

//--- verilog/fosq_pkg.sv
// Types shared by the flash command sequencer.
package fosq_pkg;
  typedef enum logic [2:0] {
    FOSQ_IDLE = 3'b000,
    FOSQ_ECHK = 3'b001,
    FOSQ_PROG = 3'b010,
    FOSQ_VRFY = 3'b011,
    FOSQ_ORD = 3'b100
  } fosq_state_t;
endpackage

//--- verilog/fosq_check.sv
// Launch-time parameter check of the command sequencer.
`include "fosq_regs.svh"
module fosq_check (
  input wire logic [7:0] cmd,
  input wire logic [2:0] slot_index,
  input wire logic [6:0] addr_hi,
  input wire logic [15:0] addr_lo,
  input wire logic mode_ok,
  input wire logic [15:0] protect,
  output logic access_error,
  output logic protect_error
);
  logic [22:0] gaddr;
  logic once_cmd;
  logic idx_bad;

  always_comb begin
    gaddr = {addr_hi, addr_lo};
    once_cmd = (cmd == `FOSQ_CMD_READ_ONCE) || (cmd == `FOSQ_CMD_PROG_ONCE);
    idx_bad = addr_lo > `FOSQ_ONCE_MAX_INDEX;
    access_error = 1'b0;
    protect_error = 1'b0;
    if (!mode_ok) begin
      access_error = 1'b1;
    end
    case (cmd)
      `FOSQ_CMD_READ_ONCE: begin
        if (slot_index != `FOSQ_SLOT_PARAM || idx_bad) begin
          access_error = 1'b1;
        end
      end
      `FOSQ_CMD_PROG_ONCE: begin
        if (slot_index != `FOSQ_SLOT_LAST || idx_bad) begin
          access_error = 1'b1;
        end
      end
      `FOSQ_CMD_PROG_PHRASE: begin
        if (slot_index != `FOSQ_SLOT_LAST) begin
          access_error = 1'b1;
        end
        if (gaddr[22:18] != `FOSQ_PFLASH_TOP) begin
          access_error = 1'b1;
        end
        if (gaddr[2:0] != 3'h0) begin
          access_error = 1'b1;
        end
        if (protect[`FOSQ_BIT_PROT_EN] && gaddr[22:16] >= protect[6:0]) begin
          protect_error = 1'b1;
        end
      end
      default: begin
        access_error = 1'b1;
      end
    endcase
    if (once_cmd) begin
      protect_error = 1'b0;
    end
  end
endmodule

//--- verilog/fosq_core.sv
// Flash command sequencer for the one-time read, phrase program and one-time program commands.
//
// The register addresses and strobed register access were left to the implementer.
`include "fosq_regs.svh"

// Operation
// - read-once code 0x04, phrase index 0..7
// - one-time field lives in block 0 info region
// - read-once returns phrase into slots 2..5
// - flash reads invalid during read-once
// - read-once access error on index, mode, phrase
// - read-once: no protection error, read errors flagged
// - program-phrase code 0x06, address, four words
// - misaligned phrase address gives access error
// - program then verify, completion after verify
// - program commands need slot index 5, mode
// - invalid program-flash address gives access error
// - protected target sets protection error
// - verify errors set verify and uncorrectable flags
// - program-once code 0x07, index 0..7, words
// - program-once checks erased, programs, verifies
// - already programmed or bad index: access error
// - block 0 reads invalid during program-once
module fosq_core (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic command_complete_flag,
  output logic nvm_req,
  output logic nvm_info,
  output logic nvm_write,
  output logic [22:0] nvm_addr,
  output logic [15:0] nvm_wdata,
  input wire logic [15:0] nvm_rdata,
  input wire logic nvm_done,
  input wire logic nvm_err,
  input wire logic nvm_uncorr,
  input wire logic [22:0] cpu_addr,
  input wire logic [15:0] cpu_rdata_in,
  output logic [15:0] cpu_rdata,
  output logic cpu_invalid
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fosq_pkg::fosq_state_t state_reg;
  logic command_complete_flag_reg;
  logic access_error_flag_reg;
  logic protection_violation_flag_reg;
  logic verify_reg;
  logic uncorr_reg;
  logic [2:0] index_reg;
  logic [15:0] config_reg;
  logic [15:0] protect_reg;
  logic [15:0] slot_reg [0:`FOSQ_SLOT_COUNT-1];
  logic [1:0] word_reg;
  logic [7:0] cmd_reg;
  logic chk_access_error_flag;
  logic chk_protection_violation_flag;
  logic stat_wr;
  logic launch_req;
  logic launch_ok;
  logic launch_bad;
  logic echk_fail;
  logic last_word;
  logic finish;
  logic word_bad;
  logic once_busy;
  logic pf_busy;

  function automatic logic [2:0] fosq_word_slot(input logic [1:0] w);
    fosq_word_slot = `FOSQ_SLOT_WORD0 + {1'b0, w};
  endfunction

  function automatic logic [15:0] fosq_slot_read(input logic [2:0] i, input logic [15:0] v);
    fosq_slot_read = (i <= `FOSQ_SLOT_LAST) ? v : 16'h0000;
  endfunction

  // ----------------------------------------------------------------
  // Launch decode
  // ----------------------------------------------------------------
  fosq_check u_check (
    .cmd(slot_reg[`FOSQ_SLOT_CMD][15:8]),
    .slot_index(index_reg),
    .addr_hi(slot_reg[`FOSQ_SLOT_CMD][6:0]),
    .addr_lo(slot_reg[`FOSQ_SLOT_PARAM]),
    .mode_ok(config_reg[`FOSQ_BIT_MODE_OK]),
    .protect(protect_reg),
    .access_error(chk_access_error_flag),
    .protect_error(chk_protection_violation_flag)
  );

  assign stat_wr = reg_wr && reg_addr == `FOSQ_OFS_STATUS;
  // A launch is only honoured while no earlier access or protection error is pending.
  assign launch_req = stat_wr && reg_wdata[`FOSQ_BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg && !access_error_flag_reg && !protection_violation_flag_reg;
  assign launch_ok = launch_req && !chk_access_error_flag && !chk_protection_violation_flag;
  assign launch_bad = launch_req && (chk_access_error_flag || chk_protection_violation_flag);
  assign last_word = word_reg == `FOSQ_LAST_WORD;
  assign echk_fail = state_reg == fosq_pkg::FOSQ_ECHK && nvm_done && (nvm_rdata != `FOSQ_ERASED_WORD || nvm_err);
  assign word_bad = nvm_rdata != slot_reg[fosq_word_slot(word_reg)];
  assign finish = echk_fail ||
    (nvm_done && last_word && (state_reg == fosq_pkg::FOSQ_VRFY || state_reg == fosq_pkg::FOSQ_ORD));
  assign command_complete_flag = command_complete_flag_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= fosq_pkg::FOSQ_IDLE;
      word_reg <= 2'h0;
      cmd_reg <= 8'h00;
    end else begin
      case (state_reg)
        fosq_pkg::FOSQ_IDLE: begin
          word_reg <= 2'h0;
          if (launch_ok) begin
            cmd_reg <= slot_reg[`FOSQ_SLOT_CMD][15:8];
            case (slot_reg[`FOSQ_SLOT_CMD][15:8])
              `FOSQ_CMD_READ_ONCE: state_reg <= fosq_pkg::FOSQ_ORD;
              `FOSQ_CMD_PROG_ONCE: state_reg <= fosq_pkg::FOSQ_ECHK;
              default: state_reg <= fosq_pkg::FOSQ_PROG;
            endcase
          end
        end
        fosq_pkg::FOSQ_ECHK: begin
          if (echk_fail) begin
            state_reg <= fosq_pkg::FOSQ_IDLE;
          end else if (nvm_done) begin
            word_reg <= word_reg + 2'h1;
            if (last_word) begin
              state_reg <= fosq_pkg::FOSQ_PROG;
            end
          end
        end
        fosq_pkg::FOSQ_PROG: begin
          if (nvm_done) begin
            word_reg <= word_reg + 2'h1;
            if (last_word) begin
              state_reg <= fosq_pkg::FOSQ_VRFY;
            end
          end
        end
        fosq_pkg::FOSQ_VRFY, fosq_pkg::FOSQ_ORD: begin
          if (nvm_done) begin
            word_reg <= word_reg + 2'h1;
            if (last_word) begin
              state_reg <= fosq_pkg::FOSQ_IDLE;
            end
          end
        end
        default: begin
          state_reg <= fosq_pkg::FOSQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Array port
  // ----------------------------------------------------------------
  // The one-time field is eight phrases of the block 0 information region, reached only here.
  always_comb begin
    nvm_req = state_reg != fosq_pkg::FOSQ_IDLE;
    nvm_info = cmd_reg != `FOSQ_CMD_PROG_PHRASE;
    nvm_write = state_reg == fosq_pkg::FOSQ_PROG;
    nvm_wdata = slot_reg[fosq_word_slot(word_reg)];
    if (nvm_info) begin
      nvm_addr = {17'h00000, slot_reg[`FOSQ_SLOT_PARAM][2:0], word_reg, 1'b0};
    end else begin
      nvm_addr = {slot_reg[`FOSQ_SLOT_CMD][6:0], slot_reg[`FOSQ_SLOT_PARAM][15:3], word_reg, 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A hardware set in the same cycle as a software clear is kept.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      command_complete_flag_reg <= 1'b1;
    end else if (launch_ok) begin
      command_complete_flag_reg <= 1'b0;
    end else if (finish) begin
      command_complete_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      access_error_flag_reg <= 1'b0;
      protection_violation_flag_reg <= 1'b0;
    end else begin
      access_error_flag_reg <= (launch_bad && chk_access_error_flag) || echk_fail || (access_error_flag_reg && !(stat_wr && reg_wdata[`FOSQ_BIT_ACCESS_ERROR_FLAG]));
      protection_violation_flag_reg <= (launch_bad && chk_protection_violation_flag) || (protection_violation_flag_reg && !(stat_wr && reg_wdata[`FOSQ_BIT_PROTECTION_VIOLATION_FLAG]));
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      verify_reg <= 1'b0;
      uncorr_reg <= 1'b0;
    end else if (launch_ok) begin
      verify_reg <= 1'b0;
      uncorr_reg <= 1'b0;
    end else if (nvm_done && state_reg == fosq_pkg::FOSQ_VRFY) begin
      verify_reg <= verify_reg || nvm_err || word_bad;
      uncorr_reg <= uncorr_reg || nvm_uncorr;
    end else if (nvm_done && state_reg == fosq_pkg::FOSQ_ORD) begin
      verify_reg <= verify_reg || nvm_err;
      uncorr_reg <= uncorr_reg || nvm_uncorr;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      index_reg <= 3'h0;
      config_reg <= `FOSQ_CONFIG_RESET;
      protect_reg <= `FOSQ_PROTECT_RESET;
    end else if (reg_wr && command_complete_flag_reg) begin
      if (reg_addr == `FOSQ_OFS_INDEX) begin
        index_reg <= reg_wdata[2:0];
      end
      if (reg_addr == `FOSQ_OFS_CONFIG) begin
        config_reg <= {15'h0000, reg_wdata[`FOSQ_BIT_MODE_OK]};
      end
      if (reg_addr == `FOSQ_OFS_PROTECT) begin
        protect_reg <= {reg_wdata[`FOSQ_BIT_PROT_EN], 8'h00, reg_wdata[6:0]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `FOSQ_SLOT_COUNT; i++) begin
        slot_reg[i] <= 16'h0000;
      end
    end else if (state_reg == fosq_pkg::FOSQ_ORD && nvm_done) begin
      slot_reg[fosq_word_slot(word_reg)] <= nvm_rdata;
    end else if (reg_wr && command_complete_flag_reg && reg_addr == `FOSQ_OFS_SLOT && index_reg <= `FOSQ_SLOT_LAST) begin
      slot_reg[index_reg] <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FOSQ_OFS_STATUS: reg_rdata <= {8'h00, command_complete_flag_reg, 1'b0, access_error_flag_reg, protection_violation_flag_reg, 2'h0, verify_reg, uncorr_reg};
        `FOSQ_OFS_INDEX: reg_rdata <= {13'h0000, index_reg};
        `FOSQ_OFS_SLOT: reg_rdata <= fosq_slot_read(index_reg, slot_reg[index_reg[2:0] % 3'h6]);
        `FOSQ_OFS_CONFIG: reg_rdata <= config_reg;
        `FOSQ_OFS_PROTECT: reg_rdata <= protect_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Processor read path
  // ----------------------------------------------------------------
  // Array contents cannot be trusted while a one-time command owns the block, so data is masked.
  assign once_busy = state_reg != fosq_pkg::FOSQ_IDLE && cmd_reg == `FOSQ_CMD_PROG_ONCE;
  assign pf_busy = state_reg != fosq_pkg::FOSQ_IDLE && cmd_reg == `FOSQ_CMD_READ_ONCE;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata <= 16'h0000;
      cpu_invalid <= 1'b0;
    end else if ((pf_busy && cpu_addr[22:18] == `FOSQ_PFLASH_TOP) ||
                 (once_busy && cpu_addr[22:18] == `FOSQ_BLOCK0_TOP)) begin
      cpu_rdata <= `FOSQ_INVALID_DATA;
      cpu_invalid <= 1'b1;
    end else begin
      cpu_rdata <= cpu_rdata_in;
      cpu_invalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_prog_done;
    state_reg == fosq_pkg::FOSQ_PROG && nvm_done && last_word;
  endsequence
  sequence s_in_verify;
    state_reg == fosq_pkg::FOSQ_VRFY && !command_complete_flag_reg;
  endsequence

  property p_launch_clears;
    @(posedge ref_clk) disable iff (!rstn) launch_ok |=> !command_complete_flag_reg && state_reg != fosq_pkg::FOSQ_IDLE;
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("Launch did not clear completion.");

  property p_ronce_index;
    @(posedge ref_clk) disable iff (!rstn)
      launch_req && slot_reg[0][15:8] == `FOSQ_CMD_READ_ONCE && index_reg != `FOSQ_SLOT_PARAM |=> access_error_flag_reg && command_complete_flag_reg;
  endproperty
  a_ronce_index: assert property (p_ronce_index) else $error("Read-once bad index not flagged.");

  property p_misaligned;
    @(posedge ref_clk) disable iff (!rstn)
      launch_req && slot_reg[0][15:8] == `FOSQ_CMD_PROG_PHRASE && slot_reg[1][2:0] != 3'h0 |=> access_error_flag_reg;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("Misaligned phrase not flagged.");

  property p_once_no_protection_violation_flag;
    @(posedge ref_clk) disable iff (!rstn)
      launch_req && slot_reg[0][15:8] != `FOSQ_CMD_PROG_PHRASE |=> !protection_violation_flag_reg;
  endproperty
  a_once_no_protection_violation_flag: assert property (p_once_no_protection_violation_flag) else $error("One-time command set protection flag.");

  property p_prog_then_verify;
    @(posedge ref_clk) disable iff (!rstn) s_prog_done |=> s_in_verify [*1] ##[0:1000] (state_reg == fosq_pkg::FOSQ_IDLE);
  endproperty
  a_prog_then_verify: assert property (p_prog_then_verify) else $error("Program not followed by verify.");

  property p_busy_no_command_complete_flag;
    @(posedge ref_clk) disable iff (!rstn) state_reg != fosq_pkg::FOSQ_IDLE |-> !command_complete_flag_reg;
  endproperty
  a_busy_no_command_complete_flag: assert property (p_busy_no_command_complete_flag) else $error("Completion set while busy.");

  property p_echk_reject;
    @(posedge ref_clk) disable iff (!rstn) echk_fail |=> access_error_flag_reg && command_complete_flag_reg && state_reg == fosq_pkg::FOSQ_IDLE;
  endproperty
  a_echk_reject: assert property (p_echk_reject) else $error("Programmed phrase not rejected.");

  property p_block0_invalid;
    @(posedge ref_clk) disable iff (!rstn)
      once_busy && cpu_addr[22:18] == `FOSQ_BLOCK0_TOP |=> cpu_invalid && cpu_rdata == `FOSQ_INVALID_DATA;
  endproperty
  a_block0_invalid: assert property (p_block0_invalid) else $error("Block 0 read not masked.");

  property p_prog_index;
    @(posedge ref_clk) disable iff (!rstn)
      launch_req && slot_reg[0][15:8] != `FOSQ_CMD_READ_ONCE && index_reg != `FOSQ_SLOT_LAST |=> access_error_flag_reg;
  endproperty
  a_prog_index: assert property (p_prog_index) else $error("Program slot index not flagged.");

  property p_verify_flag;
    @(posedge ref_clk) disable iff (!rstn)
      state_reg == fosq_pkg::FOSQ_VRFY && nvm_done && (nvm_err || word_bad) |=> verify_reg;
  endproperty
  a_verify_flag: assert property (p_verify_flag) else $error("Verify error not flagged.");
endmodule

//--- verification/tb_top.sv
// Self-checking testbench of the flash command sequencer with a behavioural array beside it.
`include "fosq_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic command_complete_flag;
  logic nvm_req;
  logic nvm_info;
  logic nvm_write;
  logic [22:0] nvm_addr;
  logic [15:0] nvm_wdata;
  logic [15:0] nvm_rdata = 16'h0000;
  logic nvm_done = 1'b0;
  logic nvm_err = 1'b0;
  logic nvm_uncorr = 1'b0;
  logic [22:0] cpu_addr = 23'h7C0000;
  logic [15:0] cpu_rdata_in = 16'hA5A5;
  logic [15:0] cpu_rdata;
  logic cpu_invalid;
  logic [15:0] mem [logic [23:0]];
  logic [15:0] ops = 16'h0000;
  logic [15:0] d;
  logic [15:0] pdat;
  logic pinv;
  logic inj = 1'b0;
  int lat = 2;
  int cnt = 0;
  int n_ops = 0;
  int fails = 0;
  int n_checks = 0;

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  fosq_core u_fosq_core (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .command_complete_flag(command_complete_flag),
    .nvm_req(nvm_req), .nvm_info(nvm_info), .nvm_write(nvm_write), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_done(nvm_done), .nvm_err(nvm_err),
    .nvm_uncorr(nvm_uncorr), .cpu_addr(cpu_addr), .cpu_rdata_in(cpu_rdata_in), .cpu_rdata(cpu_rdata),
    .cpu_invalid(cpu_invalid)
  );

  // ----------------------------------------------------------------
  // Array model
  // ----------------------------------------------------------------
  // Each word takes lat+2 cycles; unwritten words read as erased. Errors are injected on reads only.
  always @(posedge ref_clk) begin
    nvm_done <= 1'b0;
    nvm_err <= 1'b0;
    nvm_uncorr <= 1'b0;
    if (nvm_req === 1'b1 && !nvm_done) begin
      if (cnt == lat) begin
        cnt <= 0;
        nvm_done <= 1'b1;
        n_ops++;
        ops = {ops[14:0], nvm_write};
        if (nvm_write) begin
          mem[{nvm_info, nvm_addr}] = nvm_wdata;
        end else begin
          nvm_rdata <= peek({nvm_info, nvm_addr});
          nvm_err <= inj;
          nvm_uncorr <= inj;
        end
      end else begin
        cnt <= cnt + 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] peek(input logic [23:0] k);
    return mem.exists(k) ? mem[k] : `FOSQ_ERASED_WORD;
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Loads all six slots, launches, probes a processor read early in the run and waits for completion.
  task automatic run(input logic [7:0] cmd, input logic [6:0] hi, input logic [15:0] p1, input logic [2:0] idx,
                     input logic [15:0] wbase, input logic [15:0] exp_st, input int exp_n, input logic [15:0] exp_pat);
    int i;
    wr(`FOSQ_OFS_INDEX, 16'h0000);
    wr(`FOSQ_OFS_SLOT, {cmd, 1'b0, hi});
    wr(`FOSQ_OFS_INDEX, 16'h0001);
    wr(`FOSQ_OFS_SLOT, p1);
    for (i = 0; i < 4; i++) begin
      wr(`FOSQ_OFS_INDEX, 16'(i + 2));
      wr(`FOSQ_OFS_SLOT, wbase + 16'(i));
    end
    wr(`FOSQ_OFS_INDEX, {13'h0000, idx});
    ops = 16'h0000;
    n_ops = 0;
    wr(`FOSQ_OFS_STATUS, 16'h0080);
    @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    pinv = cpu_invalid;
    pdat = cpu_rdata;
    chk("command_complete_flag_running", {15'h0000, exp_n == 0}, {15'h0000, command_complete_flag});
    i = 0;
    while (command_complete_flag !== 1'b1 && i < 2000) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    if (command_complete_flag !== 1'b1) begin
      fails++;
      $display("ERROR completion expected 1 seen %b", command_complete_flag);
      report_and_stop();
    end
    rd(`FOSQ_OFS_STATUS, d);
    chk("status", exp_st, d & 16'h00B3);
    chk("array_ops", exp_pat, ops);
    if (exp_n >= 0) chk("array_count", 16'(exp_n), 16'(n_ops));
    wr(`FOSQ_OFS_STATUS, 16'h0030);
    $display("test of command %h done", cmd);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`FOSQ_OFS_STATUS, d);
    chk("status_reset", 16'h0080, d & 16'h00B3);
    rd(3'h7, d);
    chk("unmapped", 16'h0000, d);
    // A slow array shows that completion waits for the last verify read.
    lat = 5;
    run(8'h06, 7'h7C, 16'h1230, 3'h5, 16'h1100, 16'h0080, 8, 16'h00F0);
    for (int w = 0; w < 4; w++) begin
      chk("phrase_word", 16'h1100 + 16'(w), peek({1'b0, 23'h7C1230 + 23'(2 * w)}));
    end
    lat = 2;
    for (int w = 0; w < 4; w++) begin
      mem[{1'b1, 23'h000018 + 23'(2 * w)}] = 16'hC0D0 + 16'(w);
    end
    run(8'h04, 7'h00, 16'h0003, 3'h1, 16'h0000, 16'h0080, 4, 16'h0000);
    chk("read_once_mask", 16'h0001, {15'h0000, pinv});
    chk("read_once_data", `FOSQ_INVALID_DATA, pdat);
    for (int w = 0; w < 4; w++) begin
      wr(`FOSQ_OFS_INDEX, 16'(w + 2));
      rd(`FOSQ_OFS_SLOT, d);
      chk("read_once_word", 16'hC0D0 + 16'(w), d);
    end
    inj = 1'b1;
    run(8'h04, 7'h00, 16'h0007, 3'h1, 16'h0000, 16'h0083, 4, 16'h0000);
    run(8'h06, 7'h7C, 16'h1238, 3'h5, 16'h4400, 16'h0083, 8, 16'h00F0);
    inj = 1'b0;
    // Read error flags only clear at an accepted launch, so a clean read runs before the rejects.
    run(8'h04, 7'h00, 16'h0003, 3'h1, 16'h0000, 16'h0080, 4, 16'h0000);
    // Rejected launches leave the array alone and keep completion set.
    run(8'h04, 7'h00, 16'h0008, 3'h1, 16'h0000, 16'h00A0, 0, 16'h0000);
    run(8'h04, 7'h00, 16'h0002, 3'h5, 16'h0000, 16'h00A0, 0, 16'h0000);
    run(8'h06, 7'h7C, 16'h1234, 3'h5, 16'h0000, 16'h00A0, 0, 16'h0000);
    run(8'h06, 7'h7C, 16'h1240, 3'h4, 16'h0000, 16'h00A0, 0, 16'h0000);
    run(8'h06, 7'h3C, 16'h1240, 3'h5, 16'h0000, 16'h00A0, 0, 16'h0000);
    run(8'h07, 7'h00, 16'h0008, 3'h5, 16'h0000, 16'h00A0, 0, 16'h0000);
    run(8'h07, 7'h00, 16'h0002, 3'h1, 16'h0000, 16'h00A0, 0, 16'h0000);
    wr(`FOSQ_OFS_CONFIG, 16'h0000);
    run(8'h04, 7'h00, 16'h0002, 3'h1, 16'h0000, 16'h00A0, 0, 16'h0000);
    run(8'h07, 7'h00, 16'h0002, 3'h5, 16'h0000, 16'h00A0, 0, 16'h0000);
    wr(`FOSQ_OFS_CONFIG, 16'h0001);
    wr(`FOSQ_OFS_PROTECT, 16'h807C);
    run(8'h06, 7'h7C, 16'h1240, 3'h5, 16'h0000, 16'h0090, 0, 16'h0000);
    run(8'h07, 7'h00, 16'h0002, 3'h5, 16'h2200, 16'h0080, 12, 16'h00F0);
    chk("prog_once_mask", 16'h0001, {15'h0000, pinv});
    chk("prog_once_data", `FOSQ_INVALID_DATA, pdat);
    wr(`FOSQ_OFS_PROTECT, 16'h0000);
    run(8'h07, 7'h00, 16'h0002, 3'h5, 16'h3300, 16'h00A0, -1, 16'h0000);
    for (int w = 0; w < 4; w++) begin
      chk("once_word", 16'h2200 + 16'(w), peek({1'b1, 23'h000010 + 23'(2 * w)}));
    end
    @(posedge ref_clk);
    #1;
    chk("cpu_pass", cpu_rdata_in, cpu_rdata);
    report_and_stop();
  end
endmodule
